// ===== dv/dmab_sink.sv
// result sink standing in for the user logic that drains the block
`timescale 1ns/1ps
`default_nettype none
module dmab_sink (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // result stream
  input wire logic res_valid,
  output logic res_ready,
  input wire dmab_pkg::dmab_res_t res_data,
  // stall request from the bench
  input wire logic stall
);
  dmab_pkg::dmab_res_t got [$];
  ////////////////////////////////////////////////////////////////////////////////
  // ready is registered, so a stall lands one cycle late, as real user logic would
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_ready <= 1'b0;
    end else begin
      res_ready <= !stall;
      if (res_valid && res_ready) begin
        got.push_back(res_data);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clk, resetn, avs_read, avs_write, ena, op_valid, op_ready, sign_a, sign_b, sub, acc_load;
  logic res_valid, res_ready, stall, avs_waitrequest;
  logic [dmab_pkg::AVS_AW-1:0] avs_address;
  logic [3:0] be;
  logic [dmab_pkg::AVS_DW-1:0] avs_writedata, avs_readdata, rd;
  logic [7:0] cfg;
  logic [7:0] lc [8] = '{8'h02, 8'h12, 8'h22, 8'h42, 8'h62, 8'h72, 8'hf2, 8'h76};
  int ll [8] = '{3, 2, 2, 2, 1, 0, 1, 1};
  dmab_pkg::dmab_op_t a [4], b [4], ar [4];
  dmab_pkg::dmab_res_t res_data, acc_m, acc_prev;
  dmab_pkg::dmab_res_t exp_q [$];
  bit care_q [$];
  int miscompares, num_checks, run, n;
  ////////////////////////////////////////////////////////////////////////////////
  dmab_top dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ena(ena), .op_valid(op_valid), .op_ready(op_ready), .a0(a[0]),
    .a1(a[1]), .a2(a[2]), .a3(a[3]), .b0(b[0]), .b1(b[1]), .b2(b[2]), .b3(b[3]), .sign_a(sign_a),
    .sign_b(sign_b), .sub(sub), .acc_load(acc_load), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data));
  dmab_sink sink_u (.clk(clk), .resetn(resetn), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .stall(stall));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one access; the request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [dmab_pkg::AVS_AW-1:0] ad, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [dmab_pkg::AVS_AW-1:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic setcfg(input logic [7:0] v);
    bus(1'b1, dmab_pkg::REG_CFG, {24'h0, v});
    cfg = v;
  endtask
  function automatic dmab_pkg::dmab_res_t ext(input dmab_pkg::dmab_op_t v, input logic s);
    dmab_pkg::dmab_res_t r;
    int w;
    w = (cfg[1:0] == dmab_pkg::WSEL_9) ? dmab_pkg::W9 : (cfg[1:0] == dmab_pkg::WSEL_18) ? dmab_pkg::W18 : dmab_pkg::OP_W;
    for (int i = 0; i < dmab_pkg::RES_W; i++) r[i] = (i < w) ? v[i] : (s & v[w-1]);
    return r;
  endfunction
  // c is {load, sub, sign_b, sign_a}; lane i gets x+i and y+3i
  task automatic send(input dmab_pkg::dmab_op_t x, input dmab_pkg::dmab_op_t y, input logic [3:0] c);
    dmab_pkg::dmab_res_t p [4];
    dmab_pkg::dmab_res_t e;
    dmab_pkg::dmab_op_t bv;
    int k;
    for (int i = 3; i >= 0; i--) begin
      ar[i] = x + dmab_pkg::dmab_op_t'(i);
      if (cfg[dmab_pkg::CFG_CHAIN] && i > 0) ar[i] = ar[i-1];
      bv = y + dmab_pkg::dmab_op_t'(3 * i);
      a[i] <= x + dmab_pkg::dmab_op_t'(i);
      b[i] <= bv;
      p[i] = ext(ar[i], c[0]) * ext(bv, c[1]);
    end
    case (cfg[3:2])
      dmab_pkg::MODE_SIMPLE: e = p[0];
      dmab_pkg::MODE_MAC: e = c[3] ? p[0] : c[2] ? acc_m - p[0] : acc_m + p[0];
      dmab_pkg::MODE_ADD2: e = c[2] ? p[0] - p[1] : p[0] + p[1];
      default: e = c[2] ? p[0] - p[1] + p[2] - p[3] : p[0] + p[1] + p[2] + p[3];
    endcase
    if (cfg[3:2] == dmab_pkg::MODE_MAC) acc_m = e;
    run++;
    exp_q.push_back(e);
    care_q.push_back(!cfg[dmab_pkg::CFG_CHAIN] || run >= 4);
    sign_a <= c[0];
    sign_b <= c[1];
    sub <= c[2];
    acc_load <= c[3];
    op_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (op_ready !== 1'b1 && k < 50);
    @(posedge clk);
    if (k >= 50) miscompares++;
  endtask
  // released operand lines show the inverse, never the old value
  task automatic idle();
    op_valid <= 1'b0;
    run = 0;
    for (int i = 0; i < 4; i++) begin
      a[i] <= ~a[i];
      b[i] <= ~b[i];
    end
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (sink_u.got.size() < exp_q.size() && k < 500) begin
      @(posedge clk);
      k++;
    end
    `CHK("count", exp_q.size(), sink_u.got.size())
    while (exp_q.size() > 0 && sink_u.got.size() > 0) begin
      if (care_q[0]) `CHK("result", exp_q[0], sink_u.got[0])
      void'(exp_q.pop_front());
      void'(care_q.pop_front());
      void'(sink_u.got.pop_front());
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, op_valid, sign_a, sign_b, sub, acc_load, stall} = '0;
    avs_address = '0;
    avs_writedata = '0;
    be = 4'hf;
    ena = 1'b1;
    a = '{default: '0};
    b = '{default: '0};
    cfg = dmab_pkg::CFG_RST;
    acc_m = '0;
    run = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rchk("cfg", dmab_pkg::REG_CFG, 32'h02);
    rchk("stat", dmab_pkg::REG_STAT, 32'h20);
    rchk("unmapped", 5'h14, 32'h0);
    be <= 4'he;
    bus(1'b1, dmab_pkg::REG_CFG, 32'hff);
    be <= 4'hf;
    bus(1'b1, dmab_pkg::REG_STAT, 32'h1f);
    rchk("cfg", dmab_pkg::REG_CFG, 32'h02);
    rchk("stat", dmab_pkg::REG_STAT, 32'h20);
    foreach (lc[i]) begin
      setcfg(lc[i]);
      send(36'h1_2345_6789, 36'h0_0abc_def1, 4'h9);
      idle();
      n = 0;
      #1;
      while (res_valid !== 1'b1 && n < 8) begin
        @(posedge clk);
        #1;
        n++;
      end
      `CHK("latency", ll[i], n)
      drain();
    end
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 4; w++) begin
        setcfg({4'h0, m[1:0], w[1:0]});
        for (int k = 0; k < 8; k++) begin
          send(36'h8_0000_0000 - 36'h3_1357 * k, 36'hf_ffff_fe01 + 36'h1_0111 * k, {k % 5 == 0, k[2:0]});
        end
        send(36'h0_0000_01ff, 36'h0_0000_0001, 4'h3);
        idle();
        drain();
      end
    end
    setcfg(8'h8e);
    for (int k = 0; k < 5; k++) send(36'h0_0000_0101 * (k + 1), 36'h0_0000_0001, 4'h0);
    idle();
    drain();
    setcfg(8'h02);
    stall <= 1'b1;
    for (int k = 0; k < 3; k++) send(36'h7_0000_0003 + k, 36'h0_0000_0005, 4'h3);
    idle();
    repeat (10) @(posedge clk);
    `CHK("op_ready", 1'b0, op_ready)
    `CHK("res_valid", 1'b1, res_valid)
    bus(1'b0, dmab_pkg::REG_STAT, 32'h0);
    `CHK("level", 2'h2, rd[4:3])
    stall <= 1'b0;
    drain();
    setcfg(8'h06);
    send(36'h0_0123_4567, 36'h8_7654_3210, 4'hb);
    // three stages deep, so only the first set reaches the accumulator before ena drops
    acc_prev = acc_m;
    send(36'h0_0fed_cba9, 36'h0_1111_1111, 4'h1);
    send(36'h0_0000_0777, 36'h0_0000_0999, 4'h4);
    idle();
    ena <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("frozen", 1'b0, op_ready)
    rchk("acc0", dmab_pkg::REG_ACC0, acc_prev[31:0]);
    rchk("acc1", dmab_pkg::REG_ACC1, acc_prev[63:32]);
    rchk("acc2", dmab_pkg::REG_ACC2, {22'h0, acc_prev[73:64]});
    ena <= 1'b1;
    drain();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== verilog/dmab_buf.sv
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dmab_buf #(
  parameter int W = dmab_pkg::RES_W,
  parameter int DEPTH = dmab_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = cnt_ff != CW'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign count = cnt_ff;

  // pointers wrap by overflow, so depth must stay a power of two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + CW'(1);
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/dmab_lane.sv
// one multiplier lane with width and sign selection
`timescale 1ns/1ps
`default_nettype none
module dmab_lane (
  // operands
  input wire dmab_pkg::dmab_op_t opa,
  input wire dmab_pkg::dmab_op_t opb,
  // selection
  input wire logic [1:0] wsel,
  input wire logic sgn_a,
  input wire logic sgn_b,
  // product
  output dmab_pkg::dmab_res_t prod
);
  function automatic dmab_pkg::dmab_ext_t ext(input dmab_pkg::dmab_op_t op, input logic [1:0] w, input logic sgn);
    case (w)
      dmab_pkg::WSEL_9: ext = {{(dmab_pkg::EXT_W-dmab_pkg::W9){sgn & op[dmab_pkg::W9-1]}}, op[dmab_pkg::W9-1:0]};
      dmab_pkg::WSEL_18: ext = {{(dmab_pkg::EXT_W-dmab_pkg::W18){sgn & op[dmab_pkg::W18-1]}}, op[dmab_pkg::W18-1:0]};
      default: ext = {sgn & op[dmab_pkg::OP_W-1], op};
    endcase
  endfunction

  dmab_pkg::dmab_ext_t opa_x;
  dmab_pkg::dmab_ext_t opb_x;

  // RULE1: width masking
  assign opa_x = ext(opa, wsel, sgn_a);
  // RULE9: sign extension
  assign opb_x = ext(opb, wsel, sgn_b);
  // one extra bit keeps unsigned operands exact under a signed multiply
  assign prod = $signed(opa_x) * $signed(opb_x);
endmodule
`default_nettype wire

// ===== verilog/dmab_pkg.sv
// constants and types shared by the multiply-accumulate block
package dmab_pkg;
  localparam int OP_W = 36;
  localparam int EXT_W = 37;
  localparam int RES_W = 74;
  localparam int NLANE = 4;
  localparam int BUF_DEPTH = 2;
  localparam int W9 = 9;
  localparam int W18 = 18;
  localparam int AVS_AW = 5;
  localparam int AVS_DW = 32;
  localparam int ACC_MID_LSB = 32;
  localparam int ACC_HI_LSB = 64;

  typedef logic [OP_W-1:0] dmab_op_t;
  typedef logic [EXT_W-1:0] dmab_ext_t;
  typedef logic [RES_W-1:0] dmab_res_t;

  // operand width select codes
  localparam logic [1:0] WSEL_9 = 2'h0;
  localparam logic [1:0] WSEL_18 = 2'h1;
  localparam logic [1:0] WSEL_36 = 2'h2;

  // mode codes
  localparam logic [1:0] MODE_SIMPLE = 2'h0;
  localparam logic [1:0] MODE_MAC = 2'h1;
  localparam logic [1:0] MODE_ADD2 = 2'h2;
  localparam logic [1:0] MODE_ADD4 = 2'h3;

  // register byte offsets
  localparam logic [AVS_AW-1:0] REG_CFG = 5'h00;
  localparam logic [AVS_AW-1:0] REG_STAT = 5'h04;
  localparam logic [AVS_AW-1:0] REG_ACC0 = 5'h08;
  localparam logic [AVS_AW-1:0] REG_ACC1 = 5'h0c;
  localparam logic [AVS_AW-1:0] REG_ACC2 = 5'h10;

  // configuration register fields
  localparam int CFG_W = 8;
  localparam int CFG_WSEL_LSB = 0;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_BYP_IN = 4;
  localparam int CFG_BYP_PROD = 5;
  localparam int CFG_BYP_OUT = 6;
  localparam int CFG_CHAIN = 7;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h02;

  // status register fields
  localparam int STAT_S1 = 0;
  localparam int STAT_S2 = 1;
  localparam int STAT_S3 = 2;
  localparam int STAT_CNT_LSB = 3;
  localparam int STAT_ENA = 5;

  // per-operand control word carried down the pipe
  localparam int CTL_W = 4;
  localparam int CTL_SGNA = 0;
  localparam int CTL_SGNB = 1;
  localparam int CTL_SUB = 2;
  localparam int CTL_LOAD = 3;
endpackage

// ===== verilog/dmab_top.sv
// multiply-accumulate block: pipeline, mode adder, register slave
// Functional notes
// RULE1: each multiplier takes operands of 9, 18 or 36 bits, set by configuration.
// RULE2: products go straight out, or into the add/subtract/accumulate or sum stage.
// RULE3: operand input registers can chain into a shift register across multipliers.
// RULE4: optional registers at multiplier inputs, multiplier outputs and adder output.
// RULE5: four modes: simple multiply, accumulate, two-product sum, four-product sum.
// RULE6: three pipeline register sets absorb up to three cycles of latency.
// RULE7: two stages at widest width use input and product registers.
// RULE8: a third stage sits in the final output registers, one more cycle.
// RULE9: per-operand sign inputs pick signed or unsigned, driven with the operands.
// RULE10: accumulator adds or subtracts each product, restarts on load.
// RULE11: each stage has its own bypass; common clock, enable and async clear.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dmab_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register slave
  input wire logic [dmab_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dmab_pkg::AVS_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dmab_pkg::AVS_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // operand stream
  input wire logic ena,
  input wire logic op_valid,
  output logic op_ready,
  input wire dmab_pkg::dmab_op_t a0,
  input wire dmab_pkg::dmab_op_t a1,
  input wire dmab_pkg::dmab_op_t a2,
  input wire dmab_pkg::dmab_op_t a3,
  input wire dmab_pkg::dmab_op_t b0,
  input wire dmab_pkg::dmab_op_t b1,
  input wire dmab_pkg::dmab_op_t b2,
  input wire dmab_pkg::dmab_op_t b3,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic sub,
  input wire logic acc_load,
  // result stream
  output logic res_valid,
  input wire logic res_ready,
  output dmab_pkg::dmab_res_t res_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  localparam int NL = dmab_pkg::NLANE;

  function automatic dmab_pkg::dmab_res_t addsub(input dmab_pkg::dmab_res_t x, input dmab_pkg::dmab_res_t y,
                                                 input logic s);
    addsub = s ? x - y : x + y;
  endfunction

  function automatic logic [dmab_pkg::AVS_DW-1:0] word_of(input dmab_pkg::dmab_res_t v, input int sh);
    dmab_pkg::dmab_res_t t;
    t = v >> sh;
    word_of = t[dmab_pkg::AVS_DW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration and flow
  logic [dmab_pkg::CFG_W-1:0] cfg_ff;
  logic [1:0] wsel;
  logic [1:0] mode;
  logic is_mac;
  logic chain;
  logic in_byp;
  logic prod_byp;
  logic out_byp;
  logic adv;
  logic in_fire;
  logic buf_in_ready;
  logic buf_in_valid;
  logic [1:0] buf_cnt;

  assign wsel = cfg_ff[dmab_pkg::CFG_WSEL_LSB +: 2];
  assign mode = cfg_ff[dmab_pkg::CFG_MODE_LSB +: 2];
  assign is_mac = mode == dmab_pkg::MODE_MAC;
  assign chain = cfg_ff[dmab_pkg::CFG_CHAIN];
  // the chain lives in the input registers, so it overrides their bypass
  assign in_byp = cfg_ff[dmab_pkg::CFG_BYP_IN] & ~chain;
  assign prod_byp = cfg_ff[dmab_pkg::CFG_BYP_PROD];
  // the accumulator is the output register, so it cannot be bypassed
  assign out_byp = cfg_ff[dmab_pkg::CFG_BYP_OUT] & ~is_mac;
  // RULE11: common enable
  assign adv = ena & buf_in_ready;
  assign op_ready = adv;
  assign in_fire = op_valid & op_ready;

  ////////////////////////////////////////////////////////////////////////
  // stage 1: operand input registers
  dmab_pkg::dmab_op_t a_raw [NL];
  dmab_pkg::dmab_op_t b_raw [NL];
  dmab_pkg::dmab_op_t a_s1_ff [NL];
  dmab_pkg::dmab_op_t b_s1_ff [NL];
  dmab_pkg::dmab_op_t a_st1 [NL];
  dmab_pkg::dmab_op_t b_st1 [NL];
  logic [dmab_pkg::CTL_W-1:0] ctl_in;
  logic [dmab_pkg::CTL_W-1:0] ctl_s1_ff;
  logic [dmab_pkg::CTL_W-1:0] ctl1;
  logic s1_vld_ff;
  logic vld1;

  assign a_raw = '{a0, a1, a2, a3};
  assign b_raw = '{b0, b1, b2, b3};
  // RULE9: sign controls ride with operands
  assign ctl_in = {acc_load, sub, sign_b, sign_a};

  // RULE6: first register set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NL; i++) begin
        a_s1_ff[i] <= '0;
        b_s1_ff[i] <= '0;
      end
    end else if (adv) begin
      a_s1_ff[0] <= a_raw[0];
      for (int i = 1; i < NL; i++) begin
        // RULE3: shift chain
        a_s1_ff[i] <= chain ? a_s1_ff[i-1] : a_raw[i];
      end
      for (int i = 0; i < NL; i++) begin
        b_s1_ff[i] <= b_raw[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_s1_ff <= '0;
      s1_vld_ff <= 1'b0;
    end else if (adv) begin
      ctl_s1_ff <= ctl_in;
      s1_vld_ff <= op_valid;
    end
  end

  // RULE4: input stage bypass
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      a_st1[i] = in_byp ? a_raw[i] : a_s1_ff[i];
      b_st1[i] = in_byp ? b_raw[i] : b_s1_ff[i];
    end
  end
  assign ctl1 = in_byp ? ctl_in : ctl_s1_ff;
  assign vld1 = in_byp ? op_valid : s1_vld_ff;

  ////////////////////////////////////////////////////////////////////////
  // stage 2: multipliers and product registers
  dmab_pkg::dmab_res_t prod [NL];
  dmab_pkg::dmab_res_t p_s2_ff [NL];
  dmab_pkg::dmab_res_t p2 [NL];
  logic [dmab_pkg::CTL_W-1:0] ctl_s2_ff;
  logic [dmab_pkg::CTL_W-1:0] ctl2;
  logic s2_vld_ff;
  logic vld2;

  for (genvar g = 0; g < NL; g++) begin : g_lane
    dmab_lane u_lane (
      .opa(a_st1[g]),
      .opb(b_st1[g]),
      .wsel(wsel),
      .sgn_a(ctl1[dmab_pkg::CTL_SGNA]),
      .sgn_b(ctl1[dmab_pkg::CTL_SGNB]),
      .prod(prod[g])
    );
  end

  // RULE7: product registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NL; i++) begin
        p_s2_ff[i] <= '0;
      end
      ctl_s2_ff <= '0;
      s2_vld_ff <= 1'b0;
    end else if (adv) begin
      for (int i = 0; i < NL; i++) begin
        p_s2_ff[i] <= prod[i];
      end
      ctl_s2_ff <= ctl1;
      s2_vld_ff <= vld1;
    end
  end

  // RULE11: product stage bypass
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      p2[i] = prod_byp ? prod[i] : p_s2_ff[i];
    end
  end
  assign ctl2 = prod_byp ? ctl1 : ctl_s2_ff;
  assign vld2 = prod_byp ? vld1 : s2_vld_ff;

  ////////////////////////////////////////////////////////////////////////
  // stage 3: mode adder, accumulator and output register
  dmab_pkg::dmab_res_t sum;
  dmab_pkg::dmab_res_t res_s3_ff;
  dmab_pkg::dmab_res_t res3;
  logic s3_vld_ff;
  logic vld3;
  logic csub;

  assign csub = ctl2[dmab_pkg::CTL_SUB];

  // RULE2: product routing
  always_comb begin
    case (mode)
      dmab_pkg::MODE_SIMPLE: sum = p2[0];
      // RULE10: accumulate or restart
      dmab_pkg::MODE_MAC: sum = ctl2[dmab_pkg::CTL_LOAD] ? p2[0] : addsub(res_s3_ff, p2[0], csub);
      dmab_pkg::MODE_ADD2: sum = addsub(p2[0], p2[1], csub);
      // RULE5: four-product sum
      dmab_pkg::MODE_ADD4: sum = addsub(p2[0], p2[1], csub) + addsub(p2[2], p2[3], csub);
      default: sum = '0;
    endcase
  end

  // RULE8: final output registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_s3_ff <= '0;
      s3_vld_ff <= 1'b0;
    end else if (adv) begin
      s3_vld_ff <= vld2;
      // bubbles must not disturb the running sum
      if (!is_mac || vld2) begin
        res_s3_ff <= sum;
      end
    end
  end

  assign res3 = out_byp ? sum : res_s3_ff;
  assign vld3 = out_byp ? vld2 : s3_vld_ff;
  assign buf_in_valid = vld3 & ena;

  dmab_buf #(
    .W(dmab_pkg::RES_W),
    .DEPTH(dmab_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(res3),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data),
    .count(buf_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // register slave: one wait state per access
  logic ack_ff;
  logic [dmab_pkg::AVS_DW-1:0] rdata_ff;
  logic [dmab_pkg::AVS_DW-1:0] rd_word;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_comb begin
    rd_word = '0;
    case (avs_address)
      dmab_pkg::REG_CFG: rd_word[dmab_pkg::CFG_W-1:0] = cfg_ff;
      dmab_pkg::REG_STAT: begin
        rd_word[dmab_pkg::STAT_S1] = s1_vld_ff;
        rd_word[dmab_pkg::STAT_S2] = s2_vld_ff;
        rd_word[dmab_pkg::STAT_S3] = s3_vld_ff;
        rd_word[dmab_pkg::STAT_CNT_LSB +: 2] = buf_cnt;
        rd_word[dmab_pkg::STAT_ENA] = ena;
      end
      dmab_pkg::REG_ACC0: rd_word = word_of(res_s3_ff, 0);
      dmab_pkg::REG_ACC1: rd_word = word_of(res_s3_ff, dmab_pkg::ACC_MID_LSB);
      dmab_pkg::REG_ACC2: rd_word = word_of(res_s3_ff, dmab_pkg::ACC_HI_LSB);
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      if (avs_read && !ack_ff) begin
        rdata_ff <= rd_word;
      end
    end
  end

  // changing the setup with data in flight mixes old and new routing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= dmab_pkg::CFG_RST;
    end else if (avs_write && ack_ff && avs_address == dmab_pkg::REG_CFG && avs_byteenable[0]) begin
      cfg_ff <= avs_writedata[dmab_pkg::CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  logic full_pipe;
  assign full_pipe = ~in_byp & ~prod_byp & ~out_byp;

  property p_width9;
    wsel == dmab_pkg::WSEL_9 && !ctl1[dmab_pkg::CTL_SGNA] && !ctl1[dmab_pkg::CTL_SGNB]
      |-> (prod[0] >> (2 * dmab_pkg::W9)) == '0;
  endproperty
  a_width9: assert property (p_width9) else $error("9-bit unsigned product too wide"); // RULE1

  property p_simple;
    mode == dmab_pkg::MODE_SIMPLE && !out_byp && adv |=> res_s3_ff == $past(p2[0]);
  endproperty
  a_simple: assert property (p_simple) else $error("simple mode output wrong"); // RULE2

  property p_chain;
    chain && adv |=> a_s1_ff[1] == $past(a_s1_ff[0]) && a_s1_ff[3] == $past(a_s1_ff[2]);
  endproperty
  a_chain: assert property (p_chain) else $error("input chain did not shift"); // RULE3

  property p_in_reg;
    !in_byp && adv ##1 !in_byp |-> a_st1[0] == $past(a_raw[0]);
  endproperty
  a_in_reg: assert property (p_in_reg) else $error("input register not applied"); // RULE4

  property p_add2;
    mode == dmab_pkg::MODE_ADD2 && !out_byp && adv && !csub |=> res_s3_ff == $past(p2[0]) + $past(p2[1]);
  endproperty
  a_add2: assert property (p_add2) else $error("two-product sum wrong"); // RULE5

  property p_lat3;
    in_fire && full_pipe ##1 (adv && full_pipe) [*2] |=> s3_vld_ff;
  endproperty
  a_lat3: assert property (p_lat3) else $error("three-stage latency broken"); // RULE6

  property p_two;
    wsel == dmab_pkg::WSEL_36 && !prod_byp && vld1 && adv |=> s2_vld_ff;
  endproperty
  a_two: assert property (p_two) else $error("product register missed"); // RULE7

  property p_third;
    !out_byp && vld2 && adv |=> s3_vld_ff;
  endproperty
  a_third: assert property (p_third) else $error("output register missed"); // RULE8

  property p_sign;
    wsel == dmab_pkg::WSEL_9 && ctl1[dmab_pkg::CTL_SGNA] && ctl1[dmab_pkg::CTL_SGNB]
      && a_st1[0][dmab_pkg::W9-1:0] == 9'h1ff && b_st1[0][dmab_pkg::W9-1:0] == 9'h001 |-> &prod[0];
  endproperty
  a_sign: assert property (p_sign) else $error("signed product wrong"); // RULE9

  property p_mac;
    is_mac && vld2 && adv && !ctl2[dmab_pkg::CTL_LOAD] && !csub
      |=> res_s3_ff == $past(res_s3_ff) + $past(p2[0]);
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate wrong"); // RULE10

  property p_load;
    is_mac && vld2 && adv && ctl2[dmab_pkg::CTL_LOAD] |=> res_s3_ff == $past(p2[0]);
  endproperty
  a_load: assert property (p_load) else $error("accumulator restart wrong"); // RULE10

  property p_hold;
    !adv |=> $stable(s1_vld_ff) && $stable(s2_vld_ff) && $stable(s3_vld_ff) && $stable(res_s3_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("pipeline moved while held"); // RULE11

  property p_mac_run;
    is_mac && vld2 && adv ##1 is_mac && vld2 && adv;
  endproperty
  c_mac_run: cover property (p_mac_run);

  property p_add4;
    mode == dmab_pkg::MODE_ADD4 && buf_in_valid && buf_in_ready;
  endproperty
  c_add4: cover property (p_add4);

  property p_chain_run;
    chain && in_fire ##1 chain && in_fire ##1 chain && in_fire;
  endproperty
  c_chain_run: cover property (p_chain_run);

  property p_stall;
    res_valid && !res_ready && !buf_in_ready;
  endproperty
  c_stall: cover property (p_stall);
endmodule
`default_nettype wire
